// File: fuac_checker_assertions.sv
// Checker: port-level properties of the flash unlock access controller
`timescale 1ns/100ps
module fuac_checker
  import fuac_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        portMode,
  input wire logic [1:0]  optProtect,
  input wire logic [15:0] flashAddr,
  input wire logic        flashInfo,
  input wire logic [7:0]  flashWData,
  input wire logic        flashProg,
  input wire logic        flashPageErase,
  input wire logic        flashMassErase
);
  logic [7:0] lastCmd_q;
  logic [7:0] lastByte_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Last accepted command and program byte, taken at the write's ack edge
  always_ff @(posedge clock) begin
    if (wb_ack_o && wb_we_i && wb_adr_i == OFS_CMD) lastCmd_q <= wb_dat_i[7:0];
    if (wb_ack_o && wb_we_i && wb_adr_i == OFS_DATA) lastByte_q <= wb_dat_i[7:0];
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_rstIdle;
    $rose(rst_b) |-> !flashProg && !flashPageErase && !flashMassErase && flashWData == 8'hff;
  endproperty
  property p_ack;
    s_req |=> s_ackPulse;
  endproperty
  property p_oneOp;
    $onehot0({flashProg, flashPageErase, flashMassErase});
  endproperty
  property p_pageErase;
    $rose(flashPageErase) |-> lastCmd_q == CMD_PERASE;
  endproperty
  property p_massErase;
    $rose(flashMassErase) |-> lastCmd_q == CMD_MERASE && portMode && !flashInfo;
  endproperty
  property p_infoLow;
    (flashProg || flashPageErase) && flashInfo |-> flashAddr[7:6] == 2'h3;
  endproperty
  property p_infoCpu;
    (flashProg || flashPageErase) && flashInfo |-> portMode;
  endproperty
  property p_optProt;
    $rose(flashProg || flashPageErase) && !flashInfo && optProtect != 2'h0 |-> !portMode;
  endproperty
  property p_progByte;
    $rose(flashProg) |-> flashWData == lastByte_q;
  endproperty
  a_rstIdle: assert property (p_rstIdle) else $error("flash strobes active after reset");
  a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
  a_oneOp: assert property (p_oneOp) else $error("two flash operations at once");
  a_pageErase: assert property (p_pageErase) else $error("page erase without its code");
  a_massErase: assert property (p_massErase) else $error("illegal mass erase");
  a_infoLow: assert property (p_infoLow) else $error("reserved info page touched");
  a_infoCpu: assert property (p_infoCpu) else $error("cpu reached info page");
  a_optProt: assert property (p_optProt) else $error("port op despite protection");
  a_progByte: assert property (p_progByte) else $error("program byte differs");
endmodule // fuac_checker

bind fuac_flash_unlock_access_controller fuac_checker u_chk (
  .clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .portMode(portMode),
  .optProtect(optProtect), .flashAddr(flashAddr), .flashInfo(flashInfo),
  .flashWData(flashWData), .flashProg(flashProg), .flashPageErase(flashPageErase),
  .flashMassErase(flashMassErase));

// File: fuac_flash_model.sv
// Partner: behavioural flash array behind the controller
`timescale 1ns/100ps
module fuac_flash_model (
  input  wire logic        clock,
  input  wire logic [15:0] flashAddr,
  input  wire logic        flashInfo,
  input  wire logic [7:0]  flashWData,
  input  wire logic        flashProg,
  input  wire logic        flashPageErase,
  input  wire logic        flashMassErase,
  output logic      [7:0]  flashRData,
  output logic      [7:0]  nProg,
  output logic      [7:0]  nPErase,
  output logic      [7:0]  nMErase
);
  logic [7:0] mainMem [0:65535];
  logic [7:0] infoMem [0:255];
  logic       progQ;
  logic       peQ;
  logic       meQ;
  initial begin
    foreach (mainMem[i]) mainMem[i] = 8'hff;
    foreach (infoMem[i]) infoMem[i] = 8'hff;
    {nProg, nPErase, nMErase, progQ, peQ, meQ} = '0;
  end
  assign flashRData = flashInfo ? infoMem[flashAddr[7:0]] : mainMem[flashAddr];
  // Programming only clears bits; only an erase brings ones back
  always @(posedge clock) begin
    progQ <= flashProg;
    peQ <= flashPageErase;
    meQ <= flashMassErase;
    if (flashProg && !progQ) begin
      nProg <= nProg + 8'h01;
      if (flashInfo) infoMem[flashAddr[7:0]] <= infoMem[flashAddr[7:0]] & flashWData;
      else mainMem[flashAddr] <= mainMem[flashAddr] & flashWData;
    end
    if (flashPageErase && !peQ) begin
      nPErase <= nPErase + 8'h01;
      if (flashInfo) for (int i = 0; i < 64; i++) infoMem[{flashAddr[7:6], 6'(i)}] <= 8'hff;
      else for (int i = 0; i < 512; i++) mainMem[{flashAddr[15:9], 9'(i)}] <= 8'hff;
    end
    if (flashMassErase && !meQ) begin
      nMErase <= nMErase + 8'h01;
      foreach (mainMem[i]) mainMem[i] <= 8'hff;
    end
  end
endmodule // fuac_flash_model

// File: fuac_flash_unlock_access_controller.sv
// Module: flash controller unlock sequencer with Wishbone register slave
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module fuac_flash_unlock_access_controller
  import fuac_pkg::*;
#(
  parameter int PROG_US   = PROG_TIME_US,
  parameter int PERASE_US = PERASE_TIME_US,
  parameter int MERASE_US = MERASE_TIME_US
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Requester and option bits
  input  wire logic        portMode,
  input  wire logic [1:0]  optProtect,
  // Flash array
  output logic      [15:0] flashAddr,
  output logic             flashInfo,
  output logic      [7:0]  flashWData,
  output logic             flashProg,
  output logic             flashPageErase,
  output logic             flashMassErase,
  input  wire logic [7:0]  flashRData
);
  import fuac_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  fuac_state_type state_q;
  fuac_op_type    op_q;
  logic [7:0]  page_q;
  logic [7:0]  firstPage_q;
  logic [7:0]  sect_q;
  logic        sectArm_q;
  logic [15:0] freq_q;
  logic [8:0]  offset_q;
  logic        refused_q;
  logic [15:0] acc_q;
  logic [US_W-1:0] usLeft_q;
  logic        wrEv;
  logic        rdEv;
  logic [7:0]  wByte;
  logic        busy;
  logic        opDone;
  logic        usTick;
  logic        progOk;
  logic        eraseOk;
  logic        readOk;
  logic        doProg;
  logic        doPErase;
  logic        doMErase;
  logic        refuseEv;

  // ----------------------------------------
  // Access permission
  // ----------------------------------------
  function automatic logic pageAllowed(input logic [7:0] pg, input logic [7:0] sect,
                                       input logic port, input logic [1:0] opt);
    logic ok;
    ok = 1'b1;
    if (pg[PAGE_INFO_BIT]) begin
      // No sector check in the info block
      if (pg[1:0] != INFO_USER_PAGE) ok = 1'b0;
      if (!port) ok = 1'b0;
    end else begin
      // sector is page divided by sixteen
      if (!port && sect[pg[6:SECT_LSB]]) ok = 1'b0;
      if (port && (opt != 2'b00)) ok = 1'b0;
    end
    return ok;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Effects land on the acking edge, when the master samples ack
  assign wrEv  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rdEv  = wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i;
  assign wByte = wb_dat_i[7:0];
  assign busy  = (state_q == ST_BUSY);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= 32'h0000_0000;
      unique case (wb_adr_i)
        OFS_PAGE:   wb_dat_o[7:0] <= page_q;
        OFS_FREQH:  wb_dat_o[7:0] <= freq_q[15:8];
        OFS_FREQL:  wb_dat_o[7:0] <= freq_q[7:0];
        OFS_SECT:   wb_dat_o[7:0] <= sect_q;
        OFS_OFFSET: wb_dat_o[8:0] <= offset_q;
        OFS_STAT: begin
          wb_dat_o[STAT_UNLK_BIT] <= (state_q == ST_UNLOCK);
          wb_dat_o[STAT_REFU_BIT] <= refused_q;
          wb_dat_o[STAT_BUSY_BIT] <= busy;
        end
        OFS_DATA: begin
          if (readOk) wb_dat_o[7:0] <= flashRData;
        end
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Operation gating
  // ----------------------------------------
  assign readOk  = (state_q == ST_UNLOCK) && pageAllowed(page_q, sect_q, portMode, optProtect);
  assign progOk  = readOk;
  assign eraseOk = readOk;
  assign doProg  = wrEv && (wb_adr_i == OFS_DATA) && progOk;
  assign doPErase = wrEv && (wb_adr_i == OFS_CMD) && (state_q == ST_UNLOCK)
                    && (wByte == CMD_PERASE) && eraseOk;
  // Mass erase never reaches the info block
  assign doMErase = wrEv && (wb_adr_i == OFS_CMD) && (state_q == ST_UNLOCK)
                    && (wByte == CMD_MERASE) && portMode
                    && !page_q[PAGE_INFO_BIT];
  assign refuseEv = (wrEv && (wb_adr_i == OFS_DATA) && !progOk)
                  || (rdEv && (wb_adr_i == OFS_DATA) && !readOk)
                  || (wrEv && (wb_adr_i == OFS_CMD) && (state_q == ST_UNLOCK)
                      && (((wByte == CMD_PERASE) && !eraseOk)
                          || ((wByte == CMD_MERASE) && !doMErase)));

  // ----------------------------------------
  // Unlock state machine
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= ST_LOCKED;
    end else if (busy) begin
      // Register writes during an operation, other than frequency writes, do not disturb it
      if (opDone) state_q <= (op_q == OP_PROG) ? ST_UNLOCK : ST_LOCKED;
    end else if (wrEv && (wb_adr_i == OFS_PAGE) && !sectArm_q) begin
      unique case (state_q)
        ST_LOCKED: state_q <= ST_PAGE1;
        ST_KEY2: begin
          state_q <= (wByte == firstPage_q) ? ST_UNLOCK : ST_LOCKED;
        end
        ST_UNLOCK: state_q <= portMode ? ST_UNLOCK : ST_LOCKED;
        default: state_q <= ST_LOCKED;
      endcase
    end else if (wrEv && (wb_adr_i == OFS_CMD)) begin
      unique case (state_q)
        ST_PAGE1: state_q <= (wByte == CMD_KEY1) ? ST_KEY1 : ST_LOCKED;
        ST_KEY1:  state_q <= (wByte == CMD_KEY2) ? ST_KEY2 : ST_LOCKED;
        ST_UNLOCK: begin
          if (doPErase || doMErase) state_q <= ST_BUSY;
          else if ((wByte != CMD_PERASE) && (wByte != CMD_MERASE)) state_q <= ST_LOCKED;
        end
        default: state_q <= ST_LOCKED;
      endcase
    end else if (wrEv && (state_q != ST_UNLOCK) && (state_q != ST_LOCKED)) begin
      // Any other register write breaks the key sequence
      state_q <= ST_LOCKED;
    end else if (doProg) begin
      state_q <= ST_BUSY;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      op_q <= OP_PROG;
    end else if (doProg) begin
      op_q <= OP_PROG;
    end else if (doPErase) begin
      op_q <= OP_PERASE;
    end else if (doMErase) begin
      op_q <= OP_MERASE;
    end
  end

  // ----------------------------------------
  // Page select and sector protect
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      page_q      <= RST_BYTE;
      firstPage_q <= RST_BYTE;
    end else if (wrEv && (wb_adr_i == OFS_PAGE) && !sectArm_q && !busy) begin
      page_q <= wByte;
      if (state_q == ST_LOCKED) firstPage_q <= wByte;
    end
  end

  // Sector bits only ever set; only reset clears them
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sectArm_q <= 1'b0;
      sect_q    <= RST_BYTE;
    end else if (wrEv && (wb_adr_i == OFS_CMD)) begin
      sectArm_q <= (state_q == ST_LOCKED) && (wByte == CMD_SECT);
    end else if (wrEv && (wb_adr_i == OFS_PAGE) && sectArm_q) begin
      sectArm_q <= 1'b0;
      sect_q    <= sect_q | wByte;
    end
  end

  // ----------------------------------------
  // Frequency value and byte offset
  // ----------------------------------------
  // Software must load this before any program or erase
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      freq_q <= 16'h0000;
    end else if (wrEv && (wb_adr_i == OFS_FREQH)) begin
      freq_q[15:8] <= wByte;
    end else if (wrEv && (wb_adr_i == OFS_FREQL)) begin
      freq_q[7:0] <= wByte;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      offset_q <= 9'h000;
    end else if (wrEv && (wb_adr_i == OFS_OFFSET) && !busy) begin
      offset_q <= {wb_sel_i[1] & wb_dat_i[8], wByte};
    end
  end

  // ----------------------------------------
  // Refused access flag
  // ----------------------------------------
  // A new refusal wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      refused_q <= 1'b0;
    end else if (refuseEv) begin
      refused_q <= 1'b1;
    end else if (wrEv && (wb_adr_i == OFS_STAT) && wByte[STAT_REFU_BIT]) begin
      refused_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Microsecond tick from frequency value
  // ----------------------------------------
  // Accumulates 1000 per cycle; each wrap of freq kHz is one us.
  // Exact on average, so real time holds across 1 to 8 MHz.
  assign usTick = busy && (acc_q + KHZ_PER_MHZ >= freq_q);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      acc_q <= 16'h0000;
    end else if (!busy) begin
      acc_q <= 16'h0000;
    end else if (usTick) begin
      acc_q <= 16'(acc_q + KHZ_PER_MHZ - freq_q);
    end else begin
      acc_q <= 16'(acc_q + KHZ_PER_MHZ);
    end
  end

  assign opDone = busy && usTick && (usLeft_q <= 1);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      usLeft_q <= '0;
    end else if (doProg) begin
      usLeft_q <= US_W'(PROG_US);
    end else if (doPErase) begin
      usLeft_q <= US_W'(PERASE_US);
    end else if (doMErase) begin
      usLeft_q <= US_W'(MERASE_US);
    end else if (usTick && (usLeft_q != 0)) begin
      usLeft_q <= US_W'(usLeft_q - 1'b1);
    end
  end

  // ----------------------------------------
  // Flash array drive
  // ----------------------------------------
  // Byte address: page times 512 plus offset; info page is 64 bytes
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flashAddr <= 16'h0000;
      flashInfo <= 1'b0;
    end else if (!busy) begin
      flashInfo <= page_q[PAGE_INFO_BIT];
      if (page_q[PAGE_INFO_BIT]) begin
        flashAddr <= {8'h00, page_q[1:0], offset_q[5:0]};
      end else begin
        flashAddr <= {page_q[6:0], offset_q};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flashWData <= 8'hff;
    end else if (doProg) begin
      flashWData <= wByte;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flashProg      <= 1'b0;
      flashPageErase <= 1'b0;
      flashMassErase <= 1'b0;
    end else if (doProg || doPErase || doMErase) begin
      flashProg      <= doProg;
      flashPageErase <= doPErase;
      flashMassErase <= doMErase;
    end else if (opDone) begin
      flashProg      <= 1'b0;
      flashPageErase <= 1'b0;
      flashMassErase <= 1'b0;
    end
  end
endmodule // fuac_flash_unlock_access_controller

// File: fuac_flash_unlock_access_controller_tb.sv
// Testbench: register-level tests of the flash unlock access controller
`timescale 1ns/100ps
module fuac_flash_unlock_access_controller_tb;
  import fuac_pkg::*;
  logic        clock = 1'b0;
  logic        rst_b, wbCyc, wbStb, wbWe, wbAck, portMode, flashInfo;
  logic        flashProg, flashPageErase, flashMassErase;
  logic [1:0]  optProtect;
  logic [7:0]  wbAdr, flashWData, flashRData, nProg, nPErase, nMErase;
  logic [15:0] flashAddr;
  logic [31:0] wbDat, wbQ;
  int          numErrors = 0;
  int          nCompared = 0;
  int          cycles = 0;
  always #5 clock = ~clock;
  fuac_flash_unlock_access_controller #(.PROG_US(3), .PERASE_US(5), .MERASE_US(7)) i_dut (
    .clock(clock), .rst_b(rst_b), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'h3), .wb_dat_i(wbDat), .wb_dat_o(wbQ), .wb_ack_o(wbAck),
    .portMode(portMode), .optProtect(optProtect), .flashAddr(flashAddr), .flashInfo(flashInfo),
    .flashWData(flashWData), .flashProg(flashProg), .flashPageErase(flashPageErase),
    .flashMassErase(flashMassErase), .flashRData(flashRData));
  fuac_flash_model i_flash (
    .clock(clock), .flashAddr(flashAddr), .flashInfo(flashInfo), .flashWData(flashWData),
    .flashProg(flashProg), .flashPageErase(flashPageErase), .flashMassErase(flashMassErase),
    .flashRData(flashRData), .nProg(nProg), .nPErase(nPErase), .nMErase(nMErase));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nCompared++;
    if (s !== e) begin
      numErrors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Request held until ack is sampled; no latency assumed
  task automatic wbAcc(input logic we, input logic [7:0] a, input logic [15:0] d,
                       output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDat <= {16'h0, d};
    // Look at ack mid-cycle so the acking rising edge is known before it comes
    do begin
      @(negedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    @(posedge clock);
    q = wbQ;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 20) numErrors++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wbAcc(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wbAcc(1'b0, a, 16'h0, q);
    chk(q, e);
  endtask
  task automatic unlock(input logic [7:0] p);
    wr(OFS_PAGE, {8'h0, p});
    wr(OFS_CMD, {8'h0, CMD_KEY1});
    wr(OFS_CMD, {8'h0, CMD_KEY2});
    wr(OFS_PAGE, {8'h0, p});
  endtask
  task automatic waitIdle();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wbAcc(1'b0, OFS_STAT, 16'h0, q);
      n++;
    end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 100);
    if (n >= 100) numErrors++;
  endtask
  // Refused op: still unlocked with refusal flag, then clear and relock
  task automatic refused();
    rdChk(OFS_STAT, 32'h5);
    wr(OFS_STAT, 16'h4);
    wr(OFS_CMD, 16'h0);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      numErrors++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    {wbCyc, wbStb, wbWe, portMode} = '0;
    {wbAdr, wbDat, optProtect} = '0;
    rst_b = 1'b0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    chk(32'(flashWData), 32'hff);
    rdChk(OFS_STAT, 32'h0);
    rdChk(OFS_DATA, 32'h0);
    rdChk(OFS_STAT, 32'h4);
    wr(OFS_STAT, 16'h4);
    wr(OFS_FREQH, 16'h03);
    wr(OFS_FREQL, 16'he8);
    $display("test reset_locked finished");
    wr(OFS_PAGE, 16'h5);
    wr(OFS_CMD, {8'h0, CMD_KEY1});
    wr(OFS_CMD, {8'h0, CMD_KEY2});
    wr(OFS_PAGE, 16'h6);
    rdChk(OFS_STAT, 32'h0);
    unlock(8'h05);
    rdChk(OFS_STAT, 32'h1);
    wr(OFS_OFFSET, 16'h01a5);
    wr(OFS_DATA, 16'h003c);
    waitIdle();
    rdChk(OFS_STAT, 32'h1);
    rdChk(OFS_DATA, 32'h3c);
    chk(32'(i_flash.mainMem[16'h0ba5]), 32'h3c);
    wr(OFS_CMD, 16'h0);
    rdChk(OFS_STAT, 32'h0);
    $display("test unlock_program finished");
    unlock(8'h05);
    wr(OFS_CMD, {8'h0, CMD_PERASE});
    waitIdle();
    rdChk(OFS_STAT, 32'h0);
    chk(32'(nPErase), 32'h1);
    chk(32'(i_flash.mainMem[16'h0ba5]), 32'hff);
    unlock(8'h05);
    wr(OFS_PAGE, 16'h5);
    rdChk(OFS_STAT, 32'h0);
    unlock(8'h83);
    wr(OFS_CMD, {8'h0, CMD_PERASE});
    refused();
    $display("test cpu_erase finished");
    wr(OFS_CMD, {8'h0, CMD_SECT});
    wr(OFS_PAGE, 16'h1);
    rdChk(OFS_SECT, 32'h1);
    unlock(8'h05);
    wr(OFS_CMD, {8'h0, CMD_PERASE});
    refused();
    portMode <= 1'b1;
    unlock(8'h05);
    wr(OFS_CMD, {8'h0, CMD_PERASE});
    waitIdle();
    chk(32'(nPErase), 32'h2);
    unlock(8'h80);
    wr(OFS_CMD, {8'h0, CMD_PERASE});
    refused();
    unlock(8'h83);
    wr(OFS_CMD, {8'h0, CMD_PERASE});
    waitIdle();
    chk(32'(nPErase), 32'h3);
    $display("test protection finished");
    optProtect <= 2'h1;
    unlock(8'h05);
    wr(OFS_CMD, {8'h0, CMD_PERASE});
    refused();
    unlock(8'h05);
    wr(OFS_CMD, {8'h0, CMD_MERASE});
    wbAcc(1'b0, OFS_STAT, 16'h0, q);
    chk(32'(q[STAT_BUSY_BIT]), 32'h1);
    waitIdle();
    rdChk(OFS_STAT, 32'h0);
    chk(32'(nMErase), 32'h1);
    portMode <= 1'b0;
    unlock(8'h05);
    wr(OFS_CMD, {8'h0, CMD_MERASE});
    refused();
    $display("test mass_erase finished");
    stop_test();
  end
endmodule // fuac_flash_unlock_access_controller_tb

// File: fuac_pkg.sv
// Package: constants and types for the flash unlock access controller
package fuac_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_PAGE   = 8'h04;
  localparam logic [7:0] OFS_FREQH  = 8'h08;
  localparam logic [7:0] OFS_FREQL  = 8'h0c;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_DATA   = 8'h14;
  localparam logic [7:0] OFS_OFFSET = 8'h18;
  localparam logic [7:0] OFS_SECT   = 8'h1c;
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_KEY1   = 8'h73;
  localparam logic [7:0] CMD_KEY2   = 8'h8c;
  localparam logic [7:0] CMD_PERASE = 8'h95;
  localparam logic [7:0] CMD_MERASE = 8'h63;
  localparam logic [7:0] CMD_SECT   = 8'h5e;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int PAGE_INFO_BIT  = 7;
  localparam int STAT_UNLK_BIT  = 0;
  localparam int STAT_REFU_BIT  = 2;
  localparam int STAT_BUSY_BIT  = 3;
  localparam int SECT_LSB       = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] INFO_USER_PAGE = 2'h3;
  localparam int PAGE_BYTES     = 512;
  localparam int ROW_BYTES      = 64;
  localparam int PAGES_PER_SECT = 16;
  // ----------------------------------------
  // Timing: durations in microseconds
  // ----------------------------------------
  localparam int PROG_TIME_US   = 40;
  localparam int PERASE_TIME_US = 10000;
  localparam int MERASE_TIME_US = 200000;
  localparam logic [15:0] KHZ_PER_MHZ = 16'd1000;
  localparam int US_W = 18;

  typedef enum logic [5:0] {
    ST_LOCKED = 6'b000001,
    ST_PAGE1  = 6'b000010,
    ST_KEY1   = 6'b000100,
    ST_KEY2   = 6'b001000,
    ST_UNLOCK = 6'b010000,
    ST_BUSY   = 6'b100000
  } fuac_state_type;

  typedef enum logic [2:0] {
    OP_PROG   = 3'b001,
    OP_PERASE = 3'b010,
    OP_MERASE = 3'b100
  } fuac_op_type;
endpackage
